//--- include/fmfb_defs.svh
// Constants of the modem FIFO bridge
`ifndef FMFB_DEFS_SVH
`define FMFB_DEFS_SVH

// ----------------------------------------
// FIFO geometry
// ----------------------------------------
`define FMFB_DEPTH      32
`define FMFB_WIDTH      9
`define FMFB_PAR_BIT    8
`define FMFB_LVL_HI     4
`define FMFB_LVL_LO     1

// ----------------------------------------
// Threshold extension bits
// ----------------------------------------
`define FMFB_RX_THR_LSB 1'h1
`define FMFB_TX_THR_LSB 1'h0
`define FMFB_RX_THR_OFF 4'hF
`define FMFB_TX_THR_OFF 4'h0

// ----------------------------------------
// Event and mask bit positions
// ----------------------------------------
`define FMFB_EV_N       7
`define FMFB_EV_TX_LVL  0
`define FMFB_EV_TX_FULL 1
`define FMFB_EV_TX_EMPT 2
`define FMFB_EV_RX_LVL  3
`define FMFB_EV_RX_FULL 4
`define FMFB_EV_MDM_FE  5
`define FMFB_EV_URT_FE  6
`define FMFB_MASK_RST   7'h7F

`endif

//--- include/fmfb_pkg.sv
// Types of the modem FIFO bridge
package fmfb_pkg;

	typedef enum logic [1:0] {
		FMFB_SPI_ONLY = 2'h0,
		FMFB_SPI_UART = 2'h1,
		FMFB_UBM      = 2'h2
	} fmfb_mode_e;

	typedef logic [8:0] fmfb_word_t;

endpackage

//--- include/fmfb_stream_if.sv
// Valid/ready word stream between bridge modules
`timescale 1ns/1ns
interface fmfb_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- src/fmfb_bridge.sv
// Transmit and receive FIFO bridge between host paths and FSK modem
`timescale 1ns/1ns
`include "fmfb_defs.svh"
module fmfb_bridge
	import fmfb_pkg::*;
#(
	parameter int FIFO_DEPTH = `FMFB_DEPTH,
	localparam int CW        = $clog2(FIFO_DEPTH) + 1
) (
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire logic                     modem_enable,
	input  wire fmfb_mode_e               mode,
	input  wire logic [3:0]               tx_threshold,
	input  wire logic [3:0]               rx_threshold,
	input  wire logic                     mask_wr,
	input  wire logic [`FMFB_EV_N-1:0]    mask_in,
	input  wire logic                     spi_tx_wr,
	input  wire fmfb_word_t               spi_tx_wdata,
	input  wire logic                     spi_tx_rd,
	input  wire logic                     spi_rx_rd,
	input  wire logic                     spi_rx_wr,
	input  wire logic                     crc_error,
	output      fmfb_word_t               rd_data,
	output      logic                     rd_full,
	output      logic                     rd_empty,
	output      logic [3:0]               rd_level,
	output      logic                     rd_valid,
	output      fmfb_word_t               peek_data,
	output      logic                     peek_valid,
	input  wire logic                     uart_char_valid,
	input  wire fmfb_word_t               uart_char_data,
	input  wire logic                     uart_char_stop_ok,
	input  wire logic                     uart_char_break,
	output      logic                     uart_in_ready,
	input  wire logic                     demod_char_valid,
	input  wire fmfb_word_t               demod_char_data,
	input  wire logic                     demod_char_stop_ok,
	output      logic                     demod_in_ready,
	input  wire logic                     clear_to_send,
	input  wire logic                     mod_ready,
	output      logic                     mod_valid,
	output      fmfb_word_t               mod_data,
	output      logic                     mod_send_mark,
	output      logic                     uart_tx_valid,
	input  wire logic                     uart_tx_ready,
	output      fmfb_word_t               uart_tx_data,
	output      logic                     tx_full_flag,
	output      logic                     tx_empty_flag,
	output      logic                     tx_level_flag,
	output      logic                     rx_full_flag,
	output      logic                     rx_empty_flag,
	output      logic                     rx_level_flag,
	output      logic [CW-1:0]            tx_fill,
	output      logic [CW-1:0]            rx_fill,
	output      logic                     modem_frame_err,
	output      logic                     uart_frame_err,
	output      logic                     irq_event
);
	if (FIFO_DEPTH < `FMFB_DEPTH) begin : g_chk
		$error("fmfb_bridge: FIFO_DEPTH below the level field span");
	end

	typedef struct packed {
		fmfb_word_t             rd_data;
		logic                   rd_full;
		logic                   rd_empty;
		logic [3:0]             rd_level;
		logic                   rd_valid;
		fmfb_word_t             peek;
		logic                   peek_valid;
		logic [`FMFB_EV_N-1:0]  mask;
		logic                   irq;
	} fmfb_top_s;

	fmfb_top_s             st_reg;
	fmfb_top_s             st_next;
	logic                  spi_mode;
	logic                  uart_mode;
	logic                  uart_take;
	logic                  rd_take;
	logic [`FMFB_EV_N-1:0] events;

	fmfb_stream_if #(.W(`FMFB_WIDTH)) uart_s  ();
	fmfb_stream_if #(.W(`FMFB_WIDTH)) tx_in_s ();
	fmfb_stream_if #(.W(`FMFB_WIDTH)) tx_out_s();
	fmfb_stream_if #(.W(`FMFB_WIDTH)) rx_in_s ();
	fmfb_stream_if #(.W(`FMFB_WIDTH)) rx_out_s();

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign spi_mode  = mode == FMFB_SPI_ONLY;
	assign uart_mode = mode == FMFB_SPI_UART || mode == FMFB_UBM;
	// In UBM mode break command characters belong to the register path
	assign uart_take = uart_char_valid && modem_enable && uart_mode
		&& !(mode == FMFB_UBM && uart_char_break);

	// ----------------------------------------
	// Character checkers
	// ----------------------------------------
	fmfb_frame_check u_uart_chk (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.char_valid   (uart_take),
		.char_data    (uart_char_data),
		.char_stop_ok (uart_char_stop_ok),
		.out_s        (uart_s),
		.frame_err    (uart_frame_err)
	);

	fmfb_frame_check u_demod_chk (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.char_valid   (demod_char_valid && modem_enable),
		.char_data    (demod_char_data),
		.char_stop_ok (demod_char_stop_ok),
		.out_s        (rx_in_s),
		.frame_err    (modem_frame_err)
	);

	// ----------------------------------------
	// Transmit FIFO source select
	// ----------------------------------------
	assign tx_in_s.valid = spi_mode ? spi_tx_wr : uart_s.valid;
	assign tx_in_s.data  = spi_mode ? spi_tx_wdata : uart_s.data;
	assign uart_s.ready  = tx_in_s.ready;
	assign uart_in_ready = tx_in_s.ready;
	assign demod_in_ready = rx_in_s.ready;

	fmfb_fifo #(
		.W     (`FMFB_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk (core_clk),
		.nrst     (nrst),
		.in_s     (tx_in_s),
		.out_s    (tx_out_s),
		.fill     (tx_fill),
		.full     (tx_full_flag),
		.empty    (tx_empty_flag)
	);

	// ----------------------------------------
	// Modulator drain
	// ----------------------------------------
	assign tx_out_s.ready = clear_to_send && modem_enable && mod_ready;
	assign mod_valid      = clear_to_send && modem_enable && tx_out_s.valid;
	assign mod_data       = tx_out_s.data;
	assign mod_send_mark  = clear_to_send && modem_enable && tx_empty_flag;

	// ----------------------------------------
	// Receive FIFO and its drains
	// ----------------------------------------
	fmfb_fifo #(
		.W     (`FMFB_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk (core_clk),
		.nrst     (nrst),
		.in_s     (rx_in_s),
		.out_s    (rx_out_s),
		.fill     (rx_fill),
		.full     (rx_full_flag),
		.empty    (rx_empty_flag)
	);

	// Register reads only dequeue in SPI-only mode, never on a CRC error
	assign rd_take        = spi_mode && spi_rx_rd;
	assign rx_out_s.ready = uart_mode ? uart_tx_ready : (rd_take && !crc_error);
	assign uart_tx_valid  = uart_mode && rx_out_s.valid;
	assign uart_tx_data   = rx_out_s.data;

	// ----------------------------------------
	// Level flags and events
	// ----------------------------------------
	assign rx_level_flag = rx_fill > CW'({rx_threshold, `FMFB_RX_THR_LSB});
	assign tx_level_flag = tx_fill < CW'({tx_threshold, `FMFB_TX_THR_LSB});

	always_comb begin
		events                   = '0;
		events[`FMFB_EV_TX_LVL]  = tx_level_flag;
		events[`FMFB_EV_TX_FULL] = tx_full_flag;
		events[`FMFB_EV_TX_EMPT] = tx_empty_flag;
		events[`FMFB_EV_RX_LVL]  = rx_level_flag;
		events[`FMFB_EV_RX_FULL] = rx_full_flag;
		events[`FMFB_EV_MDM_FE]  = modem_frame_err;
		events[`FMFB_EV_URT_FE]  = uart_frame_err;
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	always_comb begin
		st_next          = st_reg;
		st_next.rd_valid = rd_take;
		// Writes to the receive register have no effect
		if (rd_take) begin
			st_next.rd_data  = rx_out_s.data;
			st_next.rd_full  = rx_full_flag;
			st_next.rd_empty = rx_empty_flag;
			st_next.rd_level = rx_fill[`FMFB_LVL_HI:`FMFB_LVL_LO];
		end
		st_next.peek_valid = spi_tx_rd;
		if (spi_tx_rd) begin
			st_next.peek = tx_out_s.data;
		end
		if (mask_wr) begin
			st_next.mask = mask_in;
		end
		st_next.irq = |(events & ~st_reg.mask);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg      <= '0;
			st_reg.mask <= `FMFB_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data    = st_reg.rd_data;
	assign rd_full    = st_reg.rd_full;
	assign rd_empty   = st_reg.rd_empty;
	assign rd_level   = st_reg.rd_level;
	assign rd_valid   = st_reg.rd_valid;
	assign peek_data  = st_reg.peek;
	assign peek_valid = st_reg.peek_valid;
	assign irq_event  = st_reg.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_rd_pre_status: assert property (rd_take |=> rd_valid
		&& rd_empty == $past(rx_empty_flag) && rd_full == $past(rx_full_flag))
		else $error("read frame status not pre-dequeue");
	a_rd_level_field: assert property (rd_take |=>
		rd_level == $past(rx_fill[`FMFB_LVL_HI:`FMFB_LVL_LO]))
		else $error("read frame level field wrong");
	a_crc_no_pop: assert property (rd_take && crc_error |=> rx_fill >= $past(rx_fill))
		else $error("fifo dequeued on crc error");
	a_rx_lvl_off: assert property (rx_threshold == `FMFB_RX_THR_OFF && !rx_full_flag
		|-> !rx_level_flag)
		else $error("receive level flag with disabled threshold");
	a_tx_lvl_off: assert property (tx_threshold == `FMFB_TX_THR_OFF |-> !tx_level_flag)
		else $error("transmit level flag with disabled threshold");
	a_tx_peek_hold: assert property (spi_tx_rd && !tx_out_s.ready
		|=> peek_data == $past(tx_out_s.data) && tx_fill >= $past(tx_fill))
		else $error("transmit peek wrong or dequeued");
	a_irq_masked: assert property (st_reg.mask == `FMFB_MASK_RST |=> !irq_event)
		else $error("event raised while all masked");
	a_tx_lvl_irq: assert property (tx_level_flag && !st_reg.mask[`FMFB_EV_TX_LVL]
		|=> irq_event)
		else $error("unmasked transmit level event lost");
	a_mark_empty: assert property (clear_to_send && modem_enable && tx_empty_flag
		|-> mod_send_mark && !mod_valid)
		else $error("mark tone not sent on empty fifo");
	a_rx_wr_ignored: assert property (spi_mode && spi_rx_wr && !rd_take
		|=> !rd_valid && rx_fill >= $past(rx_fill))
		else $error("write to receive register had an effect");
	a_break_kept_out: assert property (uart_char_valid && uart_char_break
		&& mode == FMFB_UBM |=> !uart_s.valid && !uart_frame_err)
		else $error("break command character reached transmit path");
	a_spi_wr_push: assert property (spi_mode && spi_tx_wr && !tx_full_flag
		&& !tx_out_s.ready |=> tx_fill == $past(tx_fill) + 1'h1)
		else $error("transmit register write not enqueued");
	a_mdm_fe_irq: assert property (modem_frame_err && !st_reg.mask[`FMFB_EV_MDM_FE]
		|=> irq_event)
		else $error("unmasked modem frame error event lost");

	c_spi_read: cover property (rd_take && !rx_empty_flag ##1 rd_valid);
	c_mod_drain: cover property (mod_valid && mod_ready);
	c_tx_full: cover property (tx_full_flag && tx_in_s.valid);
	c_uart_out: cover property (uart_tx_valid && uart_tx_ready);
	c_crc_read: cover property (rd_take && crc_error);
endmodule

//--- src/fmfb_fifo.sv
// Parameterised flip-flop FIFO with live fill count
`timescale 1ns/1ns
`include "fmfb_defs.svh"
module fmfb_fifo
	import fmfb_pkg::*;
#(
	parameter int W     = `FMFB_WIDTH,
	parameter int DEPTH = `FMFB_DEPTH
) (
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	fmfb_stream_if.snk                    in_s,
	fmfb_stream_if.src                    out_s,
	output      logic [$clog2(DEPTH):0]   fill,
	output      logic                     full,
	output      logic                     empty
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fmfb_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fmfb_fifo_s;

	fmfb_fifo_s st_reg;
	fmfb_fifo_s st_next;
	logic       push;
	logic       pop;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign full        = st_reg.cnt == (AW+1)'(DEPTH);
	assign empty       = st_reg.cnt == '0;
	assign fill        = st_reg.cnt;
	assign in_s.ready  = !full;
	assign out_s.valid = !empty;
	assign out_s.data  = st_reg.mem[st_reg.rp];
	assign push        = in_s.valid && !full;
	assign pop         = out_s.ready && !empty;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = in_s.data;
			st_next.wp             = st_reg.wp + 1'h1;
		end
		if (pop) begin
			st_next.rp = st_reg.rp + 1'h1;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_fill_bound: assert property (st_reg.cnt <= (AW+1)'(DEPTH))
		else $error("fill count above depth");
	a_full_drop: assert property (full && !out_s.ready |=> full && st_reg.wp == $past(st_reg.wp))
		else $error("entry written into full fifo");
endmodule

//--- src/fmfb_frame_check.sv
// Stop-bit check that passes good characters and drops bad ones
`timescale 1ns/1ns
`include "fmfb_defs.svh"
module fmfb_frame_check
	import fmfb_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       char_valid,
	input  wire fmfb_word_t char_data,
	input  wire logic       char_stop_ok,
	fmfb_stream_if.src      out_s,
	output      logic       frame_err
);
	typedef struct packed {
		logic       valid;
		fmfb_word_t data;
		logic       err;
	} fmfb_fc_s;

	fmfb_fc_s st_reg;
	fmfb_fc_s st_next;

	// ----------------------------------------
	// Pass or drop
	// ----------------------------------------
	always_comb begin
		st_next       = st_reg;
		st_next.valid = char_valid && char_stop_ok;
		st_next.err   = char_valid && !char_stop_ok;
		if (char_valid) begin
			st_next.data = char_data;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_s.valid = st_reg.valid;
	assign out_s.data  = st_reg.data;
	assign frame_err   = st_reg.err;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_bad_stop_drop: assert property (char_valid && !char_stop_ok |=> frame_err && !out_s.valid)
		else $error("bad stop bit not dropped");
	a_parity_kept: assert property (char_valid && char_stop_ok |=> out_s.data == $past(char_data))
		else $error("character or parity altered");
endmodule

//--- tb/fmfb_host_model.sv
// Host controller model driving the SPI strobes and the UART character path
`timescale 1ns/1ns
module fmfb_host_model
	import fmfb_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic stall_en,
	output      logic spi_tx_wr,
	output fmfb_word_t spi_tx_wdata,
	output      logic spi_tx_rd,
	output      logic spi_rx_rd,
	output      logic spi_rx_wr,
	output      logic crc_error,
	output      logic uart_char_valid,
	output fmfb_word_t uart_char_data,
	output      logic uart_char_stop_ok,
	output      logic uart_char_break,
	output      logic uart_tx_ready
);
	initial begin
		{spi_tx_wr, spi_tx_rd, spi_rx_rd, spi_rx_wr, crc_error} = 5'h00;
		{uart_char_valid, uart_char_stop_ok, uart_char_break} = 3'h0;
		spi_tx_wdata = 9'h000;
		uart_char_data = 9'h000;
	end
	// UART output sink, stalls at random when asked
	always @(negedge core_clk) begin
		uart_tx_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
	end
	// One whole 9-bit word per strobe, parity bit supplied by the caller
	task automatic spi_wr(input fmfb_word_t w);
		@(negedge core_clk);
		spi_tx_wr = 1'b1;
		spi_tx_wdata = w;
		@(negedge core_clk);
		spi_tx_wr = 1'b0;
		spi_tx_wdata = ~w;
	endtask
	// Op 0 receive read, 1 transmit peek, 2 write to receive register
	task automatic spi_op(input logic [1:0] op, input logic crc);
		@(negedge core_clk);
		spi_rx_rd = (op == 2'h0);
		spi_tx_rd = (op == 2'h1);
		spi_rx_wr = (op == 2'h2);
		crc_error = crc;
		@(negedge core_clk);
		{spi_tx_rd, spi_rx_rd, spi_rx_wr, crc_error} = 4'h0;
	endtask
	// Plain characters carry modem data; break only where asked
	task automatic uart_send(input fmfb_word_t w, input logic ok, input logic brk);
		@(negedge core_clk);
		uart_char_valid = 1'b1;
		uart_char_data = w;
		uart_char_stop_ok = ok;
		uart_char_break = brk;
		@(negedge core_clk);
		uart_char_valid = 1'b0;
		uart_char_data = ~w;
	endtask
endmodule

//--- tb/test_fsk_modem_fifo_bridge.sv
// Self-checking testbench of the modem FIFO bridge
`timescale 1ns/1ns
module test_fsk_modem_fifo_bridge
	import fmfb_pkg::*;
;
	logic        core_clk, nrst, modem_enable, mask_wr, stall_en, clear_to_send;
	logic        spi_tx_wr, spi_tx_rd, spi_rx_rd, spi_rx_wr, crc_error, rd_full, rd_empty;
	logic        rd_valid, peek_valid, uart_char_valid, uart_char_stop_ok, uart_char_break;
	logic        uart_in_ready, demod_char_valid, demod_char_stop_ok, demod_in_ready;
	logic        mod_valid, mod_send_mark, uart_tx_valid, uart_tx_ready, irq_event;
	logic        tx_full_flag, tx_empty_flag, tx_level_flag, rx_full_flag, rx_empty_flag;
	logic        rx_level_flag, modem_frame_err, uart_frame_err;
	logic        mod_ready = 1'b0;
	fmfb_mode_e  mode;
	logic [3:0]  tx_threshold, rx_threshold, rd_level;
	logic [6:0]  mask_in;
	logic [5:0]  tx_fill, rx_fill;
	fmfb_word_t  spi_tx_wdata, rd_data, peek_data, uart_char_data, demod_char_data;
	fmfb_word_t  mod_data, uart_tx_data, w;
	fmfb_word_t  exp_mod[$], exp_utx[$], rxq[$];
	logic [15:0] exp_rd[$], e;
	int          mismatches = 0;
	int          n_checks = 0;
	int          f;

	fmfb_bridge u_dut (.core_clk, .nrst, .modem_enable, .mode, .tx_threshold, .rx_threshold,
		.mask_wr, .mask_in, .spi_tx_wr, .spi_tx_wdata, .spi_tx_rd, .spi_rx_rd, .spi_rx_wr,
		.crc_error, .rd_data, .rd_full, .rd_empty, .rd_level, .rd_valid, .peek_data,
		.peek_valid, .uart_char_valid, .uart_char_data, .uart_char_stop_ok, .uart_char_break,
		.uart_in_ready, .demod_char_valid, .demod_char_data, .demod_char_stop_ok,
		.demod_in_ready, .clear_to_send, .mod_ready, .mod_valid, .mod_data, .mod_send_mark,
		.uart_tx_valid, .uart_tx_ready, .uart_tx_data, .tx_full_flag, .tx_empty_flag,
		.tx_level_flag, .rx_full_flag, .rx_empty_flag, .rx_level_flag, .tx_fill, .rx_fill,
		.modem_frame_err, .uart_frame_err, .irq_event);
	fmfb_host_model u_host (.core_clk, .stall_en, .spi_tx_wr, .spi_tx_wdata, .spi_tx_rd,
		.spi_rx_rd, .spi_rx_wr, .crc_error, .uart_char_valid, .uart_char_data,
		.uart_char_stop_ok, .uart_char_break, .uart_tx_ready);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		mod_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
	end
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] ex, input logic [15:0] got);
		n_checks++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, ex, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (mod_valid === 1'b1 && mod_ready === 1'b1) begin
			check("mod_data", 16'(exp_mod.pop_front()), 16'(mod_data));
		end
		if (uart_tx_valid === 1'b1 && uart_tx_ready === 1'b1) begin
			check("uart_tx_data", 16'(exp_utx.pop_front()), 16'(uart_tx_data));
		end
		if (rd_valid === 1'b1) begin
			e = exp_rd.pop_front();
			check("rd_status", {10'h000, e[5:0]}, {10'h000, rd_full, rd_empty, rd_level});
			if (e[15]) check("rd_data", 16'(e[14:6]), 16'(rd_data));
		end
	end
	// ----------------------------------------
	// Stimulus helpers
	// ----------------------------------------
	function automatic logic [15:0] frame(input int n, input fmfb_word_t d, input logic crc);
		logic [5:0] c;
		c = 6'(n);
		return {~crc && c != 6'h00, d, c == 6'h20, c == 6'h00, c[4:1]};
	endfunction
	task automatic demod_send(input fmfb_word_t d, input logic ok);
		@(negedge core_clk);
		demod_char_valid = 1'b1;
		demod_char_data = d;
		demod_char_stop_ok = ok;
		@(negedge core_clk);
		demod_char_valid = 1'b0;
		demod_char_data = ~d;
		check("modem_frame_err", 16'(!ok), 16'(modem_frame_err));
	endtask
	task automatic set_mask(input logic [6:0] m);
		@(negedge core_clk);
		mask_wr = 1'b1;
		mask_in = m;
		@(negedge core_clk);
		mask_wr = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	task automatic wait_drain();
		int n;
		n = 0;
		while (exp_mod.size() + exp_utx.size() + exp_rd.size() != 0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		repeat (2) @(negedge core_clk);
		if (n == 3000) begin
			mismatches++;
			$display("mismatch drain expected 0 seen %0d", exp_mod.size() + exp_utx.size());
			finish_test();
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(74));
		{nrst, modem_enable, mask_wr, stall_en, clear_to_send} = 5'h00;
		{demod_char_valid, demod_char_stop_ok} = 2'h0;
		demod_char_data = 9'h000;
		mode = FMFB_SPI_ONLY;
		{tx_threshold, rx_threshold, mask_in} = {4'h0, 4'hF, 7'h7F};
		repeat (6) @(negedge core_clk);
		check("reset flags", 16'h0060, 16'({tx_empty_flag, rx_empty_flag, tx_full_flag,
			rx_full_flag, tx_level_flag, rx_level_flag, irq_event}));
		check("reset fills", 16'h0000, {4'h0, tx_fill, rx_fill});
		nrst = 1'b1;
		modem_enable = 1'b1;
		tx_threshold = 4'h1;
		for (int i = 0; i < 33; i++) begin
			w = 9'($urandom);
			u_host.spi_wr(w);
			if (i < 32) exp_mod.push_back(w);
		end
		check("tx_fill", 16'h0020, 16'(tx_fill));
		check("tx flags", 16'h0004, 16'({tx_full_flag, tx_empty_flag, tx_level_flag}));
		u_host.spi_op(2'h1, 1'b0);
		check("peek_valid", 16'h0001, 16'(peek_valid));
		check("peek_data", 16'(exp_mod[0]), 16'(peek_data));
		check("tx_fill peek", 16'h0020, 16'(tx_fill));
		set_mask(7'h7E);
		check("irq idle", 16'h0000, 16'(irq_event));
		stall_en = 1'b1;
		clear_to_send = 1'b1;
		wait_drain();
		check("mark", 16'h0003, 16'({mod_send_mark, tx_empty_flag}));
		check("irq unmasked", 16'h0001, 16'(irq_event));
		set_mask(7'h7F);
		check("irq masked", 16'h0000, 16'(irq_event));
		clear_to_send = 1'b0;
		for (int i = 0; i < 2; i++) begin
			w = 9'($urandom);
			u_host.spi_wr(w);
			exp_mod.push_back(w);
			check("tx_level_flag", 16'(i == 0), 16'(tx_level_flag));
		end
		clear_to_send = 1'b1;
		rx_threshold = 4'h8;
		for (int i = 0; i < 35; i++) begin
			w = 9'($urandom);
			demod_send(w, i != 5);
			if (i != 5 && rxq.size() < 32) rxq.push_back(w);
			if (i == 18 || i == 19) begin
				check("rx_level_flag", 16'(i == 19), 16'(rx_level_flag));
			end
		end
		check("rx full", 16'h0801, {4'h0, rx_fill, 4'h0, demod_in_ready, rx_full_flag});
		u_host.spi_op(2'h2, 1'b0);
		exp_rd.push_back(frame(32, 9'h000, 1'b1));
		u_host.spi_op(2'h0, 1'b1);
		check("rx_fill", 16'h0020, 16'(rx_fill));
		for (f = 32; f >= 0; f--) begin
			exp_rd.push_back(frame(f, (f > 0) ? rxq.pop_front() : 9'h000, 1'b0));
			u_host.spi_op(2'h0, 1'b0);
		end
		wait_drain();
		check("rx empty", 16'h0001, 16'({rx_full_flag, rx_empty_flag}));
		mode = FMFB_SPI_UART;
		for (int i = 0; i < 6; i++) begin
			w = 9'($urandom);
			check("uart_in_ready", 16'h0001, 16'(uart_in_ready));
			u_host.uart_send(w, i != 3, 1'b0);
			check("uart_frame_err", 16'(i == 3), 16'(uart_frame_err));
			if (i != 3) exp_mod.push_back(w);
			w = 9'($urandom);
			demod_send(w, 1'b1);
			exp_utx.push_back(w);
		end
		wait_drain();
		mode = FMFB_UBM;
		for (int i = 0; i < 4; i++) begin
			w = 9'($urandom);
			u_host.uart_send(w, 1'b1, i[0]);
			if (!i[0]) exp_mod.push_back(w);
		end
		wait_drain();
		check("tx empty", 16'h0001, 16'(tx_empty_flag));
		finish_test();
	end
endmodule
